// ==== pkg/msl_pkg.sv ====
// constants, field layouts and types of the serial link slave
// assumes one 250 MHz system clock; link pins come from another domain
// Notes on behaviour
// - frame valid only with exactly 17 (command) or 29 (data) pulses
// - pulses counted on falling link clock edge
// - no parity check; length and select bit check only
// - timeout clears controls, enables; sets failure flag
// - diagnosis read clears flag; stages stay off
// - enables rewritten; direct outputs follow input pins
// - command frame: high select bit, 17 bits
// - command: select, code, argument, LSB first
// - data frame: low select bit, 29 bits
// - only correct data frame restarts timeout
// - data bits 1..28 stored as stage controls
// - upstream non-inverted, rate divided link clock
// - open-drain or push-pull by config bit
// - upstream 12- or 16-bit by format bit
// - fixed address captured at read command
// - multi-read address: register, busy, overflow
// - overflow bit set when read ignored
// - busy bit high until last frame
// - 12-bit: start, data, even parity, stops
// - data latched on falling link clock
// - data ignored while select high
// - reads ignored until last stop bit
// - stop command aborts upstream, clears pending reads
package msl_pkg;
  localparam int N_OUT = 28;
  localparam logic [4:0] CMD_LEN = 5'd17;
  localparam logic [4:0] DATA_LEN = 5'd29;
  localparam logic [4:0] UP_BITS12 = 5'd12;
  localparam logic [4:0] UP_BITS16 = 5'd16;
  // register byte offsets
  localparam logic [7:0] ADDR_CFG_A = 8'h00;
  localparam logic [7:0] ADDR_CFG_B = 8'h04;
  localparam logic [7:0] ADDR_OUT_EN = 8'h08;
  localparam logic [7:0] ADDR_OUT_CTL = 8'h0c;
  localparam logic [7:0] ADDR_DIAG = 8'h10;
  localparam logic [7:0] ADDR_UP_DATA = 8'h14;
  localparam logic [7:0] ADDR_LAST_CMD = 8'h18;
  localparam logic [7:0] ADDR_DIRECT = 8'h1c;
  // comm_config_a fields
  localparam int CFGA_PUSHPULL = 0;
  localparam int CFGA_FMT16 = 1;
  localparam int CFGA_MULTI = 2;
  localparam int CFGA_DIV_LSB = 4;
  localparam logic [7:0] CFGA_RST = 8'h00;
  localparam logic [3:0] CFGB_RST = 4'h0;
  // command codes
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_UPSTOP = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MON_TIME_US = 100;
  localparam int MON_CYC = MON_TIME_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic [0:0] {
    MSL_UP_IDLE = 1'b0,
    MSL_UP_SEND = 1'b1
  } msl_up_e;
endpackage

// ==== pkg/msl_rx_if.sv ====
// carries received frames from the downstream receiver to the core
// assumes all signals on clk_sys
interface msl_rx_if;
  logic        clk_fall;
  logic        cmd_stb;
  logic        data_stb;
  logic [28:0] frame;
  modport rx (output clk_fall, output cmd_stb, output data_stb, output frame);
  modport core (input clk_fall, input cmd_stb, input data_stb, input frame);
endinterface

// ==== hdl/msl_rx.sv ====
// downstream receiver: synchronises link pins, counts and checks frames
// assumes link clock well below clk_sys / 4
module msl_rx (
  // system
  input  wire logic clk_sys,
  input  wire logic srst,
  // link pins
  input  wire logic link_clk,
  input  wire logic link_select_n,
  input  wire logic link_data_in,
  // to core
  msl_rx_if.rx      rx
);
  logic [2:0]  s1_q, s2_q, s1_d, s2_d;
  logic        clk_prev_q, clk_prev_d, sel_prev_q, sel_prev_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [28:0] sr_q, sr_d;
  logic        cmd_q, cmd_d, dat_q, dat_d, fall_q, fall_d;
  logic        fall_now, sel_rise;

  always_comb begin
    s1_d = {link_clk, link_select_n, link_data_in};
    s2_d = s1_q;
    clk_prev_d = s2_q[2];
    sel_prev_d = s2_q[1];
    fall_now = clk_prev_q && !s2_q[2];
    sel_rise = !sel_prev_q && s2_q[1];
    fall_d = fall_now;
    cnt_d = cnt_q;
    sr_d = sr_q;
    cmd_d = 1'b0;
    dat_d = 1'b0;
    if (fall_now && !s2_q[1]) begin
      if (cnt_q < msl_pkg::DATA_LEN) begin
        sr_d[cnt_q] = s2_q[0];
      end
      if (cnt_q != 5'h1f) begin
        cnt_d = cnt_q + 5'd1;
      end
    end
    if (sel_rise) begin
      // wrong lengths fall through silently; no parity exists
      cmd_d = (cnt_q == msl_pkg::CMD_LEN) && sr_q[0];
      dat_d = (cnt_q == msl_pkg::DATA_LEN) && !sr_q[0];
      cnt_d = 5'd0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // link clock idles low; a high reset value would fake a falling edge
      s1_q <= 3'h2;
      s2_q <= 3'h2;
      clk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
      cnt_q <= 5'd0;
      sr_q <= 29'h0;
      cmd_q <= 1'b0;
      dat_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      clk_prev_q <= clk_prev_d;
      sel_prev_q <= sel_prev_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      cmd_q <= cmd_d;
      dat_q <= dat_d;
      fall_q <= fall_d;
    end
  end

  assign rx.clk_fall = fall_q;
  assign rx.cmd_stb = cmd_q;
  assign rx.data_stb = dat_q;
  assign rx.frame = sr_q;

  property p_bad_len;
    @(posedge clk_sys) disable iff (srst)
      sel_rise && cnt_q != 5'd17 && cnt_q != 5'd29 |=> !cmd_q && !dat_q;
  endproperty
  a_bad_len: assert property (p_bad_len) else $error("wrong-length frame accepted");

  property p_count_fall;
    @(posedge clk_sys) disable iff (srst)
      cnt_q != $past(cnt_q) && cnt_q != 5'd0 |-> $past(fall_now) && !$past(s2_q[1]);
  endproperty
  a_count_fall: assert property (p_count_fall) else $error("count moved off falling edge");
endmodule

// ==== hdl/msl_top.sv ====
// serial link slave: register file, timeout monitor, upstream sender
// assumes AXI4-Lite master on clk_sys; link pins asynchronous
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
module msl_top #(
  parameter int unsigned MON_CYC = msl_pkg::MON_CYC
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link pins
  input  wire logic        link_clk,
  input  wire logic        link_select_n,
  input  wire logic        link_data_in,
  output logic             upstream_data_out_o,
  output logic             upstream_data_out_oe,
  // output stages
  input  wire logic [27:0] direct_drive_input,
  output logic [27:0]      output_stage_on
);
  msl_rx_if rxi ();

  msl_rx u_rx (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .link_clk      (link_clk),
    .link_select_n (link_select_n),
    .link_data_in  (link_data_in),
    .rx            (rxi.rx)
  );

  // register state
  logic [7:0]  cfg_a_q, cfg_a_d;
  logic [3:0]  cfg_b_q, cfg_b_d;
  logic [27:0] en_q, en_d, dsel_q, dsel_d, ctl_q, ctl_d, stage_q, stage_d;
  logic [27:0] din1_q, din2_q;
  logic [31:0] up_data_q, up_data_d;
  logic [15:0] last_cmd_q, last_cmd_d;
  logic        flag_q, flag_d;
  logic [31:0] mon_q, mon_d;
  // bus state
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // upstream state
  msl_pkg::msl_up_e st_q, st_d;
  logic [15:0] shift_q, shift_d;
  logic [4:0]  bits_q, bits_d;
  logic [3:0]  div_q, div_d, fix_q, fix_d;
  logic [1:0]  left_q, left_d, idx_q, idx_d;
  logic        ovf_q, ovf_d;
  // combinational helpers
  logic        aw_hs, ar_hs, diag_rd, timeout_ev, line, fmt16, multi;
  logic        rd_cmd, stop_cmd;
  logic [31:0] wmask;
  logic [7:0]  code;
  logic [1:0]  nidx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // parity makes the ones in data plus parity even
  function automatic logic [15:0] build(input logic [7:0] d, input logic f16,
                                        input logic [3:0] a);
    logic p;
    p = ^d;
    if (f16) begin
      build = {2'b11, p, d, a, 1'b0};
    end else begin
      build = {4'hf, 2'b11, p, d, 1'b0};
    end
  endfunction

  always_comb begin
    cfg_a_d = cfg_a_q;
    cfg_b_d = cfg_b_q;
    en_d = en_q;
    dsel_d = dsel_q;
    ctl_d = ctl_q;
    up_data_d = up_data_q;
    last_cmd_d = last_cmd_q;
    flag_d = flag_q;
    mon_d = mon_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    diag_rd = 1'b0;
    fmt16 = cfg_a_q[msl_pkg::CFGA_FMT16];
    multi = cfg_a_q[msl_pkg::CFGA_MULTI];
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    // both write channels are taken together once both are offered
    aw_hs = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    ar_hs = s_axi_arvalid && !rvalid_q;
    s_axi_awready = aw_hs;
    s_axi_wready = aw_hs;
    s_axi_arready = ar_hs;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_hs) begin
      bvalid_d = 1'b1;
      bresp_d = msl_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        msl_pkg::ADDR_CFG_A: cfg_a_d = 8'(merge({24'h0, cfg_a_q}, s_axi_wdata, wmask));
        msl_pkg::ADDR_CFG_B: cfg_b_d = 4'(merge({28'h0, cfg_b_q}, s_axi_wdata, wmask));
        msl_pkg::ADDR_OUT_EN: en_d = 28'(merge({4'h0, en_q}, s_axi_wdata, wmask));
        msl_pkg::ADDR_UP_DATA: up_data_d = merge(up_data_q, s_axi_wdata, wmask);
        msl_pkg::ADDR_DIRECT: dsel_d = 28'(merge({4'h0, dsel_q}, s_axi_wdata, wmask));
        msl_pkg::ADDR_OUT_CTL, msl_pkg::ADDR_DIAG, msl_pkg::ADDR_LAST_CMD: begin
          bresp_d = msl_pkg::RESP_OKAY;
        end
        default: bresp_d = msl_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d = msl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        msl_pkg::ADDR_CFG_A: rdata_d = {24'h0, cfg_a_q};
        msl_pkg::ADDR_CFG_B: rdata_d = {28'h0, cfg_b_q};
        msl_pkg::ADDR_OUT_EN: rdata_d = {4'h0, en_q};
        msl_pkg::ADDR_OUT_CTL: rdata_d = {4'h0, ctl_q};
        msl_pkg::ADDR_DIAG: begin
          rdata_d = {31'h0, flag_q};
          diag_rd = 1'b1;
        end
        msl_pkg::ADDR_UP_DATA: rdata_d = up_data_q;
        msl_pkg::ADDR_LAST_CMD: rdata_d = {16'h0, last_cmd_q};
        msl_pkg::ADDR_DIRECT: rdata_d = {4'h0, dsel_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = msl_pkg::RESP_SLVERR;
        end
      endcase
    end
    // link supervision
    timeout_ev = (mon_q == MON_CYC - 1);
    if (mon_q != MON_CYC) begin
      mon_d = mon_q + 32'd1;
    end
    if (diag_rd) begin
      flag_d = 1'b0;
    end
    if (rxi.data_stb) begin
      mon_d = 32'h0;
      ctl_d = rxi.frame[28:1];
    end else if (timeout_ev) begin
      ctl_d = 28'h0;
      en_d = 28'h0;
      flag_d = 1'b1;
    end
    code = rxi.frame[8:1];
    rd_cmd = rxi.cmd_stb && code == msl_pkg::CMD_READ;
    stop_cmd = rxi.cmd_stb && code == msl_pkg::CMD_UPSTOP;
    if (rxi.cmd_stb) begin
      last_cmd_d = rxi.frame[16:1];
    end
  end

  // upstream sender
  always_comb begin
    st_d = st_q;
    shift_d = shift_q;
    bits_d = bits_q;
    div_d = div_q;
    left_d = left_q;
    idx_d = idx_q;
    fix_d = fix_q;
    ovf_d = ovf_q;
    nidx = idx_q + 2'd1;
    if (st_q == msl_pkg::MSL_UP_SEND && rxi.clk_fall) begin
      // bit time is (divider + 1) link clock periods
      if (div_q == cfg_a_q[msl_pkg::CFGA_DIV_LSB +: 4]) begin
        div_d = 4'h0;
        shift_d = {1'b1, shift_q[15:1]};
        bits_d = bits_q - 5'd1;
        if (bits_q == 5'd1) begin
          if (left_q != 2'd0) begin
            idx_d = nidx;
            left_d = left_q - 2'd1;
            shift_d = build(up_data_q[{nidx, 3'b000} +: 8], fmt16,
                            multi ? {nidx, left_q != 2'd1, ovf_q} : fix_q);
            bits_d = fmt16 ? msl_pkg::UP_BITS16 : msl_pkg::UP_BITS12;
            ovf_d = 1'b0;
          end else begin
            st_d = msl_pkg::MSL_UP_IDLE;
          end
        end
      end else begin
        div_d = div_q + 4'h1;
      end
    end
    if (rd_cmd && st_q == msl_pkg::MSL_UP_IDLE) begin
      st_d = msl_pkg::MSL_UP_SEND;
      idx_d = 2'd0;
      left_d = rxi.frame[10:9];
      fix_d = cfg_b_q;
      div_d = 4'h0;
      shift_d = build(up_data_q[7:0], fmt16,
                      multi ? {2'b00, rxi.frame[10:9] != 2'd0, ovf_q} : cfg_b_q);
      bits_d = fmt16 ? msl_pkg::UP_BITS16 : msl_pkg::UP_BITS12;
      ovf_d = 1'b0;
    end
    if (rd_cmd && st_q == msl_pkg::MSL_UP_SEND) begin
      ovf_d = 1'b1;
    end
    if (stop_cmd) begin
      st_d = msl_pkg::MSL_UP_IDLE;
      left_d = 2'd0;
      shift_d = 16'hffff;
    end
  end

  assign stage_d = en_q & ((dsel_q & din2_q) | (~dsel_q & ctl_q));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_a_q <= msl_pkg::CFGA_RST;
      cfg_b_q <= msl_pkg::CFGB_RST;
      en_q <= 28'h0;
      dsel_q <= 28'h0;
      ctl_q <= 28'h0;
      stage_q <= 28'h0;
      din1_q <= 28'h0;
      din2_q <= 28'h0;
      up_data_q <= 32'h0;
      last_cmd_q <= 16'h0;
      flag_q <= 1'b0;
      mon_q <= 32'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
      st_q <= msl_pkg::MSL_UP_IDLE;
      shift_q <= 16'hffff;
      bits_q <= 5'd0;
      div_q <= 4'h0;
      left_q <= 2'd0;
      idx_q <= 2'd0;
      fix_q <= 4'h0;
      ovf_q <= 1'b0;
    end else begin
      cfg_a_q <= cfg_a_d;
      cfg_b_q <= cfg_b_d;
      en_q <= en_d;
      dsel_q <= dsel_d;
      ctl_q <= ctl_d;
      stage_q <= stage_d;
      din1_q <= direct_drive_input;
      din2_q <= din1_q;
      up_data_q <= up_data_d;
      last_cmd_q <= last_cmd_d;
      flag_q <= flag_d;
      mon_q <= mon_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      div_q <= div_d;
      left_q <= left_d;
      idx_q <= idx_d;
      fix_q <= fix_d;
      ovf_q <= ovf_d;
    end
  end

  // idle line high; open drain only pulls low
  assign line = (st_q == msl_pkg::MSL_UP_SEND) ? shift_q[0] : 1'b1;
  assign upstream_data_out_o = cfg_a_q[msl_pkg::CFGA_PUSHPULL] ? line : 1'b0;
  assign upstream_data_out_oe = cfg_a_q[msl_pkg::CFGA_PUSHPULL] ? 1'b1 : !line;
  assign output_stage_on = stage_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  sequence s_read_idle;
    rd_cmd && st_q == msl_pkg::MSL_UP_IDLE && !stop_cmd;
  endsequence
  sequence s_start_bit;
    st_q == msl_pkg::MSL_UP_SEND && shift_q[0] == 1'b0;
  endsequence

  property p_timeout;
    @(posedge clk_sys) disable iff (srst)
      timeout_ev && !rxi.data_stb |=> flag_q && en_q == 28'h0 && ctl_q == 28'h0
        ##1 stage_q == 28'h0;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not shut outputs");

  property p_diag_clear;
    @(posedge clk_sys) disable iff (srst)
      diag_rd && !timeout_ev |=> !flag_q;
  endproperty
  a_diag_clear: assert property (p_diag_clear) else $error("diag read kept flag");

  property p_restart;
    @(posedge clk_sys) disable iff (srst)
      rxi.data_stb |=> mon_q == 32'h0 && ctl_q == $past(rxi.frame[28:1]);
  endproperty
  a_restart: assert property (p_restart) else $error("data frame not stored");

  property p_direct;
    @(posedge clk_sys) disable iff (srst)
      en_q[0] && dsel_q[0] && $stable(en_q) && $stable(dsel_q)
        |=> output_stage_on[0] == $past(din2_q[0]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct drive not followed");

  property p_start;
    @(posedge clk_sys) disable iff (srst)
      s_read_idle |=> s_start_bit;
  endproperty
  a_start: assert property (p_start) else $error("read did not start frame");

  property p_busy_ignore;
    @(posedge clk_sys) disable iff (srst)
      rd_cmd && st_q == msl_pkg::MSL_UP_SEND && !stop_cmd
        |=> ovf_q && (idx_q == $past(idx_q) || $past(rxi.clk_fall));
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("busy read not ignored");

  property p_stop;
    @(posedge clk_sys) disable iff (srst)
      stop_cmd |=> st_q == msl_pkg::MSL_UP_IDLE && left_q == 2'd0 ##1 line;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");

  property p_odrain;
    @(posedge clk_sys) disable iff (srst)
      !cfg_a_q[msl_pkg::CFGA_PUSHPULL] |-> !upstream_data_out_o && upstream_data_out_oe == !line;
  endproperty
  a_odrain: assert property (p_odrain) else $error("open drain drives high");
endmodule

// ==== verif/msl_link_master.sv ====
// controller side of the serial link: clock, select, data, upstream receiver
// assumes up_line is the resolved upstream wire with a pull-up
module msl_link_master #(
  parameter int HALF_NS = 40
) (
  // downstream
  output logic      link_clk,
  output logic      link_select_n,
  output logic      link_data_in,
  // upstream
  input  wire logic up_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rx_got;
  logic [15:0] rx_fifo [$];
  int          rx_k = -1;
  int          rx_wait = 0;
  int          up_div = 0;
  initial begin
    link_clk      = 1'b0;
    link_select_n = 1'b1;
    link_data_in  = 1'b0;
  end
  // select and data move with the rising edge
  task automatic tick(input logic sel_n, input logic d);
    link_clk      = 1'b1;
    link_select_n = sel_n;
    link_data_in  = d;
    #(HALF_NS);
    link_clk = 1'b0;
    #(HALF_NS);
  endtask
  // clock stands still after the passive phase
  task automatic send(input logic [31:0] bits, input int len);
    for (int i = 0; i < len; i++) tick(1'b0, bits[i]);
    // released data line toggles so a stale bit is never read as valid
    tick(1'b1, ~link_data_in);
    tick(1'b1, ~link_data_in);
  endtask
  // receiver runs free: frames often start inside the command's passive phase
  always @(negedge link_clk) begin
    if (rx_k < 0) begin
      if (up_line === 1'b0) begin
        rx_got  = 16'hfffe;
        rx_k    = 1;
        rx_wait = up_div;
      end
    end else if (rx_wait != 0) begin
      rx_wait--;
    end else begin
      rx_got[rx_k] = up_line;
      rx_wait      = up_div;
      rx_k++;
      if (rx_k == 16) begin
        rx_fifo.push_back(rx_got);
        rx_k = -1;
      end
    end
  end
  // divider must be known before the read command goes out
  task automatic set_div(input int div);
    up_div = div;
  endtask
  // oldest captured frame, all ones when none arrives
  task automatic recv(output logic [15:0] got);
    int t;
    got = 16'hffff;
    t = 0;
    while ((t < 64 || rx_k >= 0) && rx_fifo.size() == 0) begin
      tick(1'b1, ~link_data_in);
      t++;
    end
    if (rx_fifo.size() != 0)
      got = rx_fifo.pop_front();
  endtask
  // let the line settle, then forget partial frames
  task automatic flush();
    repeat (20) tick(1'b1, ~link_data_in);
    rx_fifo.delete();
    rx_k = -1;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench: registers, downstream frames, timeout, upstream frames
// assumes msl_link_master plays the controller; upstream wire has a pull-up
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MON = 2000;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [27:0] direct_drive_input = 28'h0;
  logic        awready, wready, bvalid, arready, rvalid, up_o, up_oe;
  logic        link_clk, link_select_n, link_data_in;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [27:0] output_stage_on;
  logic [31:0] seed = 32'h0000a7db;
  int          n_errors = 0;
  int          compares = 0;
  wire         up_line = up_oe ? up_o : 1'b1;

  always #2 clk_sys = ~clk_sys;

  msl_top #(.MON_CYC(MON)) msl_top_inst (
    .clk_sys(clk_sys), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_clk(link_clk), .link_select_n(link_select_n), .link_data_in(link_data_in),
    .upstream_data_out_o(up_o), .upstream_data_out_oe(up_oe),
    .direct_drive_input(direct_drive_input), .output_stage_on(output_stage_on)
  );
  msl_link_master msl_link_master_inst (
    .link_clk(link_clk), .link_select_n(link_select_n),
    .link_data_in(link_data_in), .up_line(up_line)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] up_frame(input logic f16, input logic [3:0] a,
                                           input logic [7:0] d);
    if (f16)
      return {2'b11, ^d, d, a, 1'b0};
    return {4'hf, 2'b11, ^d, d, 1'b0};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk_sys); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check({30'h0, rresp}, {30'h0, er});
    check(rdata, exp);
  endtask
  task automatic summarize();
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // run is about 50 us; generous margin before declaring a hang
  initial begin
    #(200_000);
    n_errors++;
    summarize();
  end

  initial begin
    logic [31:0] p, d, ctl;
    logic [15:0] g;
    logic [7:0]  c;
    logic [3:0]  a;
    int          lens [4];
    lens = '{29, 28, 30, 29};
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(msl_pkg::ADDR_DIAG, 32'h0, msl_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, msl_pkg::RESP_SLVERR);
    wr(8'h24, rnd(), msl_pkg::RESP_SLVERR);
    wr(msl_pkg::ADDR_OUT_EN, 32'h0fffffff, msl_pkg::RESP_OKAY);
    wr(msl_pkg::ADDR_DIRECT, 32'h0, msl_pkg::RESP_OKAY);
    ctl = 32'h0;
    // wrong lengths must leave the controls alone
    foreach (lens[i]) begin
      p = rnd() & 32'h0fffffff;
      msl_link_master_inst.send({p[27:0], 1'b0}, lens[i]);
      if (lens[i] == 29)
        ctl = p;
      rd(msl_pkg::ADDR_OUT_CTL, ctl, msl_pkg::RESP_OKAY);
      check({4'h0, output_stage_on}, ctl);
    end
    msl_link_master_inst.send(rnd(), 5);
    rd(msl_pkg::ADDR_OUT_CTL, ctl, msl_pkg::RESP_OKAY);
    p = rnd();
    c = 8'h80 | p[15:8];
    msl_link_master_inst.send({p[7:0], c, 1'b1}, 17);
    rd(msl_pkg::ADDR_LAST_CMD, {16'h0, p[7:0], c}, msl_pkg::RESP_OKAY);
    msl_link_master_inst.send({p[23:16], 8'h81, 1'b1}, 16);
    rd(msl_pkg::ADDR_LAST_CMD, {16'h0, p[7:0], c}, msl_pkg::RESP_OKAY);
    // commands arrived late, yet the data-frame silence still expires
    repeat (1500) @(posedge clk_sys);
    rd(msl_pkg::ADDR_DIAG, 32'h1, msl_pkg::RESP_OKAY);
    rd(msl_pkg::ADDR_OUT_CTL, 32'h0, msl_pkg::RESP_OKAY);
    rd(msl_pkg::ADDR_OUT_EN, 32'h0, msl_pkg::RESP_OKAY);
    rd(msl_pkg::ADDR_DIAG, 32'h0, msl_pkg::RESP_OKAY);
    check({4'h0, output_stage_on}, 32'h0);
    p = rnd();
    direct_drive_input <= p[27:0];
    wr(msl_pkg::ADDR_DIRECT, 32'h0fffffff, msl_pkg::RESP_OKAY);
    wr(msl_pkg::ADDR_OUT_EN, 32'h0fffffff, msl_pkg::RESP_OKAY);
    repeat (6) @(posedge clk_sys);
    check({4'h0, output_stage_on}, {4'h0, p[27:0]});
    d = rnd();
    wr(msl_pkg::ADDR_UP_DATA, d, msl_pkg::RESP_OKAY);
    wr(msl_pkg::ADDR_CFG_A, 32'h0, msl_pkg::RESP_OKAY);
    msl_link_master_inst.set_div(0);
    msl_link_master_inst.send({8'h00, msl_pkg::CMD_READ, 1'b1}, 17);
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b0, 4'h0, d[7:0])});
    p = rnd();
    a = p[3:0];
    wr(msl_pkg::ADDR_CFG_B, {28'h0, a}, msl_pkg::RESP_OKAY);
    wr(msl_pkg::ADDR_CFG_A, 32'h13, msl_pkg::RESP_OKAY);
    msl_link_master_inst.set_div(1);
    msl_link_master_inst.send({8'h00, msl_pkg::CMD_READ, 1'b1}, 17);
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, a, d[7:0])});
    wr(msl_pkg::ADDR_CFG_A, 32'h07, msl_pkg::RESP_OKAY);
    msl_link_master_inst.set_div(0);
    msl_link_master_inst.send({8'h01, msl_pkg::CMD_READ, 1'b1}, 17);
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, 4'b0010, d[7:0])});
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, 4'b0100, d[15:8])});
    // second read lands in frame 3, so frame 4 reports it
    msl_link_master_inst.send({8'h03, msl_pkg::CMD_READ, 1'b1}, 17);
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, 4'b0010, d[7:0])});
    msl_link_master_inst.send({8'h00, msl_pkg::CMD_READ, 1'b1}, 17);
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, 4'b0110, d[15:8])});
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, 4'b1010, d[23:16])});
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, 4'b1101, d[31:24])});
    // abort a four-frame read during its third frame
    msl_link_master_inst.send({8'h03, msl_pkg::CMD_READ, 1'b1}, 17);
    msl_link_master_inst.recv(g);
    check({16'h0, g}, {16'h0, up_frame(1'b1, 4'b0010, d[7:0])});
    msl_link_master_inst.send({8'h00, msl_pkg::CMD_UPSTOP, 1'b1}, 17);
    msl_link_master_inst.flush();
    msl_link_master_inst.recv(g);
    check({16'h0, g}, 32'h0000ffff);
    summarize();
  end
endmodule
